/* core/meas_cfg.svh */
// Constants of the pulse measurement block: encodings, widths and timing counts.
// Assumes inclusion by bare name from the package and the design module.
`ifndef MEAS_CFG_SVH
`define MEAS_CFG_SVH

// ----------------------------------------
// Encodings
// ----------------------------------------
`define TMO_INACTIVE     2'h0
`define TMO_DEFAULT      2'h1
`define TMO_LEVEL_DEP    2'h2
`define WIN_COUNT        3
`define PAIR_COUNT       10

// ----------------------------------------
// Widths and counts
// ----------------------------------------
`define TIME_W           32
`define ADC_W            12
`define ADC_SAMPLES      128
`define ADC_SAMPLE_LOG2  7
`define EDGE_HIST        3
`define DUTY_ONE         16'hFFFF
`define CAM_CYCLE_DEG    720

`endif

/* core/meas_pkg.sv */
// Types shared by the pulse measurement block.
// Assumes meas_cfg.svh is on the include path.
`include "meas_cfg.svh"

package meas_pkg;

    // ----------------------------------------
    // Modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        MODE_ASYNC       = 3'h0,
        MODE_PULSE_QUAL  = 3'h1,
        MODE_GATE_ENABLE = 3'h2,
        MODE_GATE_VALID  = 3'h3,
        MODE_ADDITIVE    = 3'h4
    } meas_mode_t;

    typedef struct packed {
        meas_mode_t  mode;
        logic        meas_high;
        logic        gate_high;
        logic [4:0]  channel;
        logic [1:0]  window_index;
        logic [1:0]  timeout_mode;
        logic [15:0] pulse_number;
        logic [31:0] default_value;
        logic [31:0] timeout_interval;
    } meas_cfg_t;

    typedef struct packed {
        logic [31:0] frequency_period;
        logic [31:0] period;
        logic [31:0] high_time;
        logic [31:0] low_time;
        logic [15:0] duty_high;
        logic [15:0] duty_low;
        logic [11:0] voltage;
        logic        timeout;
    } async_result_t;

endpackage

/* core/angle_window_pulse_meas.sv */
// Angle-window pulse measurement for one channel of a paired digital input board.
// Assumes windows and channel pins arrive from outside the clock domain; ADC samples are on clk.
`timescale 1ns/1ps
`default_nettype none
`include "meas_cfg.svh"

module angle_window_pulse_meas
    import meas_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // Configuration
    input  wire meas_cfg_t             cfg,
    // Input channels and angle windows
    input  wire logic [19:0]           channel_pins,
    input  wire logic [2:0]            window_active,
    input  wire logic                  cam_cycle_start,
    // Converter samples
    input  wire logic [11:0]           adc_sample,
    input  wire logic                  adc_valid,
    // Angle-synchronous result
    output logic [31:0]                angle_result,
    output logic                       angle_result_valid,
    output logic                       angle_timeout,
    // Asynchronous result
    output async_result_t              async_result,
    output logic                       async_result_valid,
    // Configuration status
    output logic                       cfg_rejected
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Pins and windows are asynchronous; only the second stage and its delayed copy are read.
    logic [23:0] sync1_q;
    logic [23:0] sync2_q;
    logic [23:0] prev_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= 24'h000000;
            sync2_q <= 24'h000000;
            prev_q  <= 24'h000000;
        end else begin
            sync1_q <= {cam_cycle_start, window_active, channel_pins};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    logic       meas_lvl;
    logic       gate_lvl;
    logic       meas_act;
    logic       gate_act;
    logic       meas_edge;
    logic       win_now;
    logic       win_prev;
    logic       win_open;
    logic       win_close;
    logic       cam_tick;
    logic [4:0] gate_ch;

    always_comb begin
        gate_ch   = cfg.channel ^ 5'h01;
        meas_lvl  = sync2_q[cfg.channel];
        gate_lvl  = sync2_q[gate_ch];
        meas_act  = (meas_lvl == cfg.meas_high);
        gate_act  = (gate_lvl == cfg.gate_high);
        meas_edge = sync2_q[cfg.channel] ^ prev_q[cfg.channel];
        win_now   = (cfg.window_index < 2'h3) ? sync2_q[20 + cfg.window_index] : 1'b0;
        win_prev  = (cfg.window_index < 2'h3) ? prev_q[20 + cfg.window_index] : 1'b0;
        win_open  = win_now && !win_prev;
        win_close = !win_now && win_prev;
        cam_tick  = sync2_q[23] && !prev_q[23];
    end

    // ----------------------------------------
    // Configuration check
    // ----------------------------------------
    logic mode_angle;

    always_comb begin
        mode_angle = (cfg.mode != MODE_ASYNC);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_rejected <= 1'b0;
        end else begin
            cfg_rejected <= (cfg.timeout_mode == 2'h3) ||
                            ((cfg.mode != MODE_ADDITIVE) && (cfg.mode != MODE_ASYNC) &&
                             (cfg.timeout_mode == `TMO_LEVEL_DEP));
        end
    end

    // ----------------------------------------
    // Free running time base
    // ----------------------------------------
    logic [31:0] now_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            now_q <= 32'h00000000;
        end else begin
            now_q <= now_q + 32'h00000001;
        end
    end

    // ----------------------------------------
    // Angle window pulse tracking
    // ----------------------------------------
    logic [31:0] pulse_start_q;
    logic        pulse_in_win_q;
    logic        gate_ok_q;
    logic        gate_seen_q;
    logic [15:0] count_q;
    logic [31:0] width_q;
    logic [31:0] sum_q;
    logic [31:0] win_start_q;
    logic        win_edge_q;
    logic        pulse_end;
    logic        qualifies;
    logic        gate_open_q;

    always_comb begin
        pulse_end = win_now && !meas_act && (prev_q[cfg.channel] == cfg.meas_high) && pulse_in_win_q;
        case (cfg.mode)
            MODE_GATE_ENABLE: qualifies = gate_ok_q && gate_act;
            MODE_GATE_VALID:  qualifies = gate_seen_q;
            default:          qualifies = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pulse_in_win_q <= 1'b0;
            pulse_start_q  <= 32'h00000000;
            gate_ok_q      <= 1'b0;
            gate_seen_q    <= 1'b0;
        end else if (!win_now) begin
            pulse_in_win_q <= 1'b0;
        end else if (meas_edge && meas_act) begin
            pulse_in_win_q <= 1'b1;
            pulse_start_q  <= now_q;
            gate_ok_q      <= gate_act;
            gate_seen_q    <= 1'b0;
        end else if (pulse_in_win_q) begin
            if (!gate_act) begin
                gate_ok_q <= 1'b0;
            end
            // A gating pulse counts only if it both starts and ends inside the measured pulse.
            if (!gate_act && prev_q[gate_ch] == cfg.gate_high && gate_open_q) begin
                gate_seen_q <= 1'b1;
            end
            if (pulse_end) begin
                pulse_in_win_q <= 1'b0;
            end
        end
    end

    // Validate tracking: a full active gating pulse inside the measured pulse.
    always_ff @(posedge clk) begin
        if (srst) begin
            gate_open_q <= 1'b0;
        end else if (!pulse_in_win_q || (meas_edge && meas_act)) begin
            gate_open_q <= 1'b0;
        end else if (gate_act && prev_q[gate_ch] != cfg.gate_high) begin
            gate_open_q <= 1'b1;
        end
    end

    logic validate_hit;

    always_comb begin
        validate_hit = gate_open_q && !gate_act;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count_q <= 16'h0000;
            width_q <= 32'h00000000;
        end else if (win_open) begin
            count_q <= 16'h0000;
            width_q <= 32'h00000000;
        end else if (pulse_end && (qualifies || (cfg.mode == MODE_GATE_VALID && validate_hit))) begin
            count_q <= count_q + 16'h0001;
            if (count_q + 16'h0001 == cfg.pulse_number) begin
                width_q <= now_q - pulse_start_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sum_q       <= 32'h00000000;
            win_start_q <= 32'h00000000;
            win_edge_q  <= 1'b0;
        end else if (win_open) begin
            sum_q       <= meas_act ? 32'h00000001 : 32'h00000000;
            win_start_q <= now_q;
            win_edge_q  <= meas_edge;
        end else if (win_now) begin
            if (meas_act) begin
                sum_q <= sum_q + 32'h00000001;
            end
            if (meas_edge) begin
                win_edge_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Hand-over at the upper window limit
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            angle_result       <= 32'h00000000;
            angle_result_valid <= 1'b0;
            angle_timeout      <= 1'b0;
        end else begin
            angle_result_valid <= win_close && mode_angle;
            angle_timeout      <= 1'b0;
            if (win_close && mode_angle) begin
                if (cfg.mode == MODE_ADDITIVE) begin
                    angle_result <= sum_q;
                    if (!win_edge_q && cfg.timeout_mode != `TMO_INACTIVE) begin
                        angle_timeout <= 1'b1;
                        if (cfg.timeout_mode == `TMO_DEFAULT) begin
                            angle_result <= cfg.default_value;
                        end else begin
                            angle_result <= meas_act ? (now_q - win_start_q) : 32'h00000000;
                        end
                    end
                end else if (count_q < cfg.pulse_number && cfg.timeout_mode == `TMO_DEFAULT) begin
                    angle_result  <= cfg.default_value;
                    angle_timeout <= 1'b1;
                end else begin
                    angle_result <= width_q;
                end
            end
        end
    end

    // ----------------------------------------
    // Asynchronous measurements
    // ----------------------------------------
    // Three-edge history; newest edge in slot 0.
    logic [31:0] edge_time_q [0:2];
    logic        edge_lvl_q;
    logic [31:0] last_edge_q;
    logic        tmo_fired_q;
    logic        calc_go;
    logic        angle_pending;

    always_comb begin
        angle_pending = win_now && mode_angle;
        calc_go       = !angle_pending || cam_tick;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            edge_time_q[0] <= 32'h00000000;
            edge_time_q[1] <= 32'h00000000;
            edge_time_q[2] <= 32'h00000000;
            edge_lvl_q     <= 1'b0;
        end else if (meas_edge) begin
            edge_time_q[0] <= now_q;
            edge_time_q[1] <= edge_time_q[0];
            edge_time_q[2] <= edge_time_q[1];
            edge_lvl_q     <= meas_lvl;
        end
    end

    logic        tmo_now;

    always_comb begin
        tmo_now = (cfg.timeout_mode != `TMO_INACTIVE) && !tmo_fired_q && !meas_edge &&
                  (now_q - last_edge_q >= cfg.timeout_interval);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            last_edge_q <= 32'h00000000;
            tmo_fired_q <= 1'b0;
        end else if (meas_edge) begin
            last_edge_q <= now_q;
            tmo_fired_q <= 1'b0;
        end else if (tmo_now) begin
            tmo_fired_q <= 1'b1;
        end
    end

    // Voltage mean over 128 samples, started at a computation instant.
    logic [18:0] adc_sum_q;
    logic [7:0]  adc_cnt_q;
    logic        adc_busy_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            adc_sum_q  <= 19'h00000;
            adc_cnt_q  <= 8'h00;
            adc_busy_q <= 1'b0;
        end else if (!adc_busy_q) begin
            if (calc_go) begin
                adc_busy_q <= 1'b1;
                adc_sum_q  <= 19'h00000;
                adc_cnt_q  <= 8'h00;
            end
        end else if (adc_valid) begin
            adc_sum_q <= adc_sum_q + {7'h00, adc_sample};
            adc_cnt_q <= adc_cnt_q + 8'h01;
            if (adc_cnt_q == 8'(`ADC_SAMPLES - 1)) begin
                adc_busy_q <= 1'b0;
            end
        end
    end

    logic [31:0] p_full;
    logic [31:0] p_high;

    always_comb begin
        p_full = edge_time_q[0] - edge_time_q[2];
        p_high = edge_lvl_q ? (edge_time_q[1] - edge_time_q[2]) : (edge_time_q[0] - edge_time_q[1]);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            async_result       <= '0;
            async_result_valid <= 1'b0;
        end else begin
            async_result_valid <= calc_go && !angle_pending || cam_tick || tmo_now;
            if (calc_go) begin
                async_result.period           <= p_full;
                async_result.frequency_period <= p_full;
                async_result.high_time        <= p_high;
                async_result.low_time         <= p_full - p_high;
            end
            // A level-dependent timeout value stands until a fresh edge renews the history.
            if (calc_go && !(tmo_fired_q && cfg.timeout_mode == `TMO_LEVEL_DEP)) begin
                async_result.duty_high        <= (p_full == 32'h0) ? 16'h0000 : 16'(({p_high, 16'h0000} / {32'h0, p_full}));
                async_result.duty_low         <= (p_full == 32'h0) ? 16'h0000 : 16'(({p_full - p_high, 16'h0000} / {32'h0, p_full}));
            end
            if (adc_busy_q && adc_valid && adc_cnt_q == 8'(`ADC_SAMPLES - 1)) begin
                async_result.voltage <= 12'((adc_sum_q + {7'h00, adc_sample}) >> `ADC_SAMPLE_LOG2);
            end
            async_result.timeout <= tmo_now;
            if (tmo_now && cfg.timeout_mode == `TMO_LEVEL_DEP) begin
                async_result.duty_high <= meas_lvl ? `DUTY_ONE : 16'h0000;
                async_result.duty_low  <= meas_lvl ? 16'h0000 : `DUTY_ONE;
            end
        end
    end

endmodule
`default_nettype wire

/* test/angle_window_pulse_meas_sva.sv */
// Port assertions for the angle window pulse measurement block.
// Assumes one clock and a synchronous active-high reset; attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
`include "meas_cfg.svh"

module meas_port_checker
    import meas_pkg::*;
(
    // Clock and reset
    input wire logic          clk,
    input wire logic          srst,
    // Stimulus side
    input wire meas_cfg_t     cfg,
    input wire logic [19:0]   channel_pins,
    input wire logic [2:0]    window_active,
    input wire logic          cam_cycle_start,
    // Results
    input wire logic [31:0]   angle_result,
    input wire logic          angle_result_valid,
    input wire logic          angle_timeout,
    input wire async_result_t async_result,
    input wire logic          async_result_valid,
    input wire logic          cfg_rejected
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    logic pin_now;
    logic width_mode;
    assign pin_now    = channel_pins[cfg.channel];
    assign width_mode = cfg.mode inside {MODE_PULSE_QUAL, MODE_GATE_ENABLE, MODE_GATE_VALID};

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    async_every_cycle_a: assert property ((cfg.mode == MODE_ASYNC && $rose(cam_cycle_start)) |-> ##[1:300] async_result_valid)
        else $error("no async result within a cam cycle");
    result_at_limit_a: assert property ((cfg.mode != MODE_ASYNC && cfg.window_index != 2'h3 &&
        $fell(window_active[cfg.window_index])) |-> ##[1:6] angle_result_valid)
        else $error("no angle result after the upper window limit");
    valid_one_cycle_a: assert property (angle_result_valid |=> !angle_result_valid)
        else $error("angle result strobe longer than one cycle");
    timeout_default_a: assert property ((angle_timeout && cfg.timeout_mode == `TMO_DEFAULT) |->
        angle_result == cfg.default_value)
        else $error("timeout result differs from default value");
    inactive_quiet_a: assert property ((cfg.timeout_mode == `TMO_INACTIVE) |-> !angle_timeout)
        else $error("timeout raised while monitoring inactive");
    width_reject_a: assert property ((width_mode && cfg.timeout_mode == `TMO_LEVEL_DEP && $stable(cfg)) |->
        ##[0:2] cfg_rejected)
        else $error("level dependent timeout on width mode not rejected");
    additive_accept_a: assert property ($stable(cfg)[*3] ##0 cfg.mode == MODE_ADDITIVE |-> !cfg_rejected)
        else $error("additive mode rejected");
    duty_level_a: assert property ($stable(channel_pins)[*4] ##0 ($rose(async_result.timeout) &&
        cfg.timeout_mode == `TMO_LEVEL_DEP) |-> ##[0:1] (async_result.duty_high == (pin_now ? `DUTY_ONE : 16'h0000)
        && async_result.duty_low == (pin_now ? 16'h0000 : `DUTY_ONE)))
        else $error("duty timeout value does not follow input level");
    additive_level_a: assert property ((angle_timeout && cfg.mode == MODE_ADDITIVE && cfg.timeout_mode == `TMO_LEVEL_DEP
        && pin_now != cfg.meas_high) |-> angle_result == 32'h0000_0000)
        else $error("additive level timeout not zero for inactive input");

    // ----------------------------------------
    // Covers
    // ----------------------------------------
    cover property (angle_result_valid && angle_timeout);
    cover property (angle_result_valid && !angle_timeout);
    cover property ($rose(async_result.timeout));
    cover property (cfg_rejected);
endmodule

bind angle_window_pulse_meas meas_port_checker u_meas_port_checker (
    .clk(clk), .srst(srst), .cfg(cfg), .channel_pins(channel_pins), .window_active(window_active),
    .cam_cycle_start(cam_cycle_start), .angle_result(angle_result), .angle_result_valid(angle_result_valid),
    .angle_timeout(angle_timeout), .async_result(async_result), .async_result_valid(async_result_valid),
    .cfg_rejected(cfg_rejected));
`default_nettype wire

/* test/result_consumer.sv */
// Model of the simulation side that takes over measure values from the block.
// Assumes result strobes last one cycle and are sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module result_consumer
    import meas_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          srst,
    // Results from the block
    input  wire logic [31:0]   angle_result,
    input  wire logic          angle_result_valid,
    input  wire logic          angle_timeout,
    input  wire async_result_t async_result,
    // Captured values
    output logic [31:0]        last_value_q,
    output logic               last_timeout_q,
    output int                 n_results_q,
    output int                 n_async_to_q
);
    logic async_to_q;

    // The strobe stands one cycle only, so the value is taken in that very cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            last_value_q   <= 32'h0000_0000;
            last_timeout_q <= 1'b0;
            n_results_q    <= 0;
        end else if (angle_result_valid) begin
            last_value_q   <= angle_result;
            last_timeout_q <= angle_timeout;
            n_results_q    <= n_results_q + 1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            async_to_q   <= 1'b0;
            n_async_to_q <= 0;
        end else begin
            async_to_q <= async_result.timeout;
            if (async_result.timeout && !async_to_q) begin
                n_async_to_q <= n_async_to_q + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* test/angle_window_pulse_meas_test.sv */
// Self-checking bench for the angle window pulse measurement block.
// Assumes the design package and header are compiled first; windows last 60 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "meas_cfg.svh"

`define CHK_EQ(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module angle_window_pulse_meas_test
    import meas_pkg::*;
;
    typedef struct {
        meas_mode_t mode;
        int mh, gh, ch, win, n, tmo, s0, l0, s1, l1, gs, gl, ev, et;
    } row_t;

    localparam logic [31:0] DEF = 32'h0000_D00D;

    logic          clk = 1'b0;
    logic          srst;
    meas_cfg_t     cfg;
    logic [19:0]   channel_pins;
    logic [2:0]    window_active;
    logic          cam_cycle_start;
    logic [11:0]   adc_sample;
    logic          adc_valid;
    logic [31:0]   angle_result;
    logic          angle_result_valid;
    logic          angle_timeout;
    async_result_t async_result;
    logic          async_result_valid;
    logic          cfg_rejected;
    logic [31:0]   last_value;
    logic          last_timeout;
    int            n_results;
    int            n_async_to;
    int            mismatches = 0;
    int            n_tests = 0;
    int            base;

    // Ordinary cases: mode, polarities, channel, window, n, timeout mode, pulses, gate, expected value and timeout.
    row_t rows[15] = '{
        '{MODE_PULSE_QUAL, 1, 1, 4, 0, 1, 1, -3, 8, 20, 12, 0, 0, 12, 0},
        '{MODE_PULSE_QUAL, 0, 1, 5, 1, 2, 1, 10, 5, 30, 7, 0, 0, 7, 0},
        '{MODE_PULSE_QUAL, 0, 1, 5, 1, 3, 1, 10, 5, 30, 7, 0, 0, DEF, 1},
        '{MODE_GATE_ENABLE, 1, 1, 2, 2, 1, 1, 10, 5, 30, 6, 28, 12, 6, 0},
        '{MODE_GATE_ENABLE, 0, 0, 3, 0, 1, 1, 10, 5, 30, 6, 8, 10, 5, 0},
        '{MODE_GATE_ENABLE, 1, 0, 6, 1, 1, 1, 10, 5, 30, 6, 28, 12, 6, 0},
        '{MODE_GATE_ENABLE, 0, 1, 19, 2, 1, 1, 10, 5, 30, 6, 8, 10, 5, 0},
        '{MODE_GATE_VALID, 1, 1, 8, 0, 1, 1, 10, 5, 30, 10, 33, 3, 10, 0},
        '{MODE_GATE_VALID, 0, 0, 9, 1, 1, 1, 10, 8, 30, 4, 12, 2, 8, 0},
        '{MODE_GATE_VALID, 1, 0, 10, 2, 1, 1, 10, 5, 30, 10, 33, 3, 10, 0},
        '{MODE_GATE_VALID, 0, 1, 11, 0, 1, 1, 10, 8, 30, 4, 12, 2, 8, 0},
        '{MODE_ADDITIVE, 1, 1, 0, 1, 1, 0, -3, 8, 55, 10, 0, 0, 10, 0},
        '{MODE_ADDITIVE, 0, 1, 1, 2, 1, 1, 0, 0, 0, 0, 0, 0, DEF, 1},
        '{MODE_ADDITIVE, 1, 1, 12, 0, 1, 2, 0, 0, 0, 0, 0, 0, 0, 1},
        '{MODE_ADDITIVE, 0, 1, 13, 1, 1, 2, -6, 90, 0, 0, 0, 0, 60, 1}
    };

    angle_window_pulse_meas u_angle_window_pulse_meas (
        .clk(clk), .srst(srst), .cfg(cfg), .channel_pins(channel_pins), .window_active(window_active),
        .cam_cycle_start(cam_cycle_start), .adc_sample(adc_sample), .adc_valid(adc_valid),
        .angle_result(angle_result), .angle_result_valid(angle_result_valid), .angle_timeout(angle_timeout),
        .async_result(async_result), .async_result_valid(async_result_valid), .cfg_rejected(cfg_rejected));

    result_consumer u_result_consumer (
        .clk(clk), .srst(srst), .angle_result(angle_result), .angle_result_valid(angle_result_valid),
        .angle_timeout(angle_timeout), .async_result(async_result), .last_value_q(last_value),
        .last_timeout_q(last_timeout), .n_results_q(n_results), .n_async_to_q(n_async_to));

    always #50 clk = ~clk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [19:0] pins_for(input row_t r, input int t);
        logic [19:0] p;
        p = 20'h00000;
        p[r.ch] = r.mh[0] ~^ ((t >= r.s0 && t < r.s0 + r.l0) || (t >= r.s1 && t < r.s1 + r.l1));
        p[r.ch ^ 1] = r.gh[0] ~^ (t >= r.gs && t < r.gs + r.gl);
        return p;
    endfunction

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic run_row(input row_t r);
        int cnt;
        int g;
        cfg <= '{mode: r.mode, meas_high: r.mh[0], gate_high: r.gh[0], channel: 5'(r.ch), window_index: 2'(r.win),
                 timeout_mode: 2'(r.tmo), pulse_number: 16'(r.n), default_value: DEF, timeout_interval: 32'h0000_0100};
        @(posedge clk);
        channel_pins    <= pins_for(r, -1000);
        cam_cycle_start <= 1'b1;
        repeat (6) @(posedge clk) cam_cycle_start <= 1'b0;
        cnt = n_results;
        for (int t = -6; t < 67; t++) begin
            @(posedge clk);
            channel_pins  <= pins_for(r, t);
            window_active <= (t >= 0 && t < 60) ? (3'h1 << r.win) : 3'h0;
        end
        g = 0;
        while (n_results == cnt && g < 50) begin
            @(posedge clk);
            g++;
        end
        `CHK_EQ(last_value, 32'(r.ev))
        `CHK_EQ(last_timeout, r.et[0])
        `CHK_EQ(cfg_rejected, 1'b0)
    endtask

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    // The tests take about 2,000 cycles; the margin covers a slow but correct design.
    initial begin
        #(20000 * 100);
        mismatches++;
        finish_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        cfg = '0;
        channel_pins = 20'h00000;
        window_active = 3'h0;
        cam_cycle_start = 1'b0;
        adc_sample = 12'h5A3;
        adc_valid = 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK_EQ(angle_result_valid, 1'b0)
        `CHK_EQ(async_result_valid, 1'b1)
        `CHK_EQ(cfg_rejected, 1'b0)
        $display("reset test done");
        @(posedge clk);
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        cfg <= '{mode: MODE_PULSE_QUAL, meas_high: 1'b1, gate_high: 1'b1, channel: 5'h04, window_index: 2'h0,
                 timeout_mode: `TMO_LEVEL_DEP, pulse_number: 16'h0001, default_value: DEF, timeout_interval: 32'h40};
        repeat (4) @(posedge clk);
        `CHK_EQ(cfg_rejected, 1'b1)
        cfg.timeout_mode <= 2'h3;
        repeat (4) @(posedge clk);
        `CHK_EQ(cfg_rejected, 1'b1)
        $display("reject test done");
        cfg <= '{mode: MODE_ASYNC, meas_high: 1'b1, gate_high: 1'b1, channel: 5'h0A, window_index: 2'h0,
                 timeout_mode: `TMO_LEVEL_DEP, pulse_number: 16'h0001, default_value: DEF, timeout_interval: 32'h40};
        for (int t = 0; t < 400; t++) begin
            @(posedge clk);
            channel_pins    <= (t % 20 < 5) ? 20'h00400 : 20'h00000;
            cam_cycle_start <= (t == 200);
            if (t == 100) base = n_async_to;
        end
        #1;
        `CHK_EQ(async_result.period, 32'h0000_0014)
        `CHK_EQ(async_result.high_time, 32'h0000_0005)
        `CHK_EQ(async_result.low_time, 32'h0000_000F)
        `CHK_EQ(async_result.duty_high, 16'h4000)
        `CHK_EQ(async_result.voltage, 12'h5A3)
        `CHK_EQ(n_async_to, base)
        @(posedge clk) channel_pins <= 20'h00400;
        repeat (200) @(posedge clk);
        #1;
        `CHK_EQ(n_async_to, base + 1)
        `CHK_EQ(async_result.duty_high, `DUTY_ONE)
        @(posedge clk) channel_pins <= 20'h00000;
        repeat (200) @(posedge clk);
        #1;
        `CHK_EQ(n_async_to, base + 2)
        `CHK_EQ(async_result.duty_low, `DUTY_ONE)
        $display("async test done");
        @(posedge clk) srst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK_EQ(async_result, async_result_t'(0))
        `CHK_EQ(angle_result, 32'h0000_0000)
        @(posedge clk) srst <= 1'b0;
        $display("mid-run reset test done");
        finish_test();
    end
endmodule
`default_nettype wire
